// File: logic/bftl_pkg.sv
// constants, register map and types of the breaker failure timer
`default_nettype none
package bftl_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_NS = 5000000;
   localparam int STEP_MS = 5;
   localparam int TICK_CYCLES_DEF = STEP_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 18;
   localparam int DLY_W = 19;
   localparam int RETRIP_DLY_MS = 100;
   localparam int BFAIL_DLY_MS = 200;
   localparam logic [DLY_W-1:0] RETRIP_DLY_RST =
      DLY_W'(RETRIP_DLY_MS / STEP_MS);
   localparam logic [DLY_W-1:0] BFAIL_DLY_RST =
      DLY_W'(BFAIL_DLY_MS / STEP_MS);
   localparam int CUR_W = 16;
   localparam int TS_W = 32;
   localparam int ADR_W = 8;
   localparam int LOG_DEPTH = 12;
   localparam int LOG_IDX_W = 4;
   localparam int WORD_SEL_W = 3;

   // register byte offsets
   localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] REG_RETRIP_DLY = 8'h04;
   localparam logic [ADR_W-1:0] REG_BFAIL_DLY = 8'h08;
   localparam logic [ADR_W-1:0] REG_PHASE_THR = 8'h0c;
   localparam logic [ADR_W-1:0] REG_RES_THR = 8'h10;
   localparam logic [ADR_W-1:0] REG_EVT_MASK = 8'h14;
   localparam logic [ADR_W-1:0] REG_STATUS = 8'h18;
   localparam logic [ADR_W-1:0] REG_LOG_SEL = 8'h1c;
   localparam logic [ADR_W-1:0] REG_LOG_DATA = 8'h20;

   // control field layout and reset values
   localparam int MODE_W = 4;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RETRIP_BIT = 4;
   localparam int CTRL_GROUP_LSB = 5;
   localparam int GROUP_W = 3;
   localparam logic [7:0] CTRL_RST = 8'h10;
   localparam logic [CUR_W-1:0] PHASE_THR_RST = 16'h0014;
   localparam logic [CUR_W-1:0] RES_THR_RST = 16'h04b0;
   localparam logic [15:0] EVT_MASK_RST = 16'hffff;
   localparam int LOG_WORD_LSB = 4;
   localparam int LOG_CNT_LSB = 8;

   // criterion selector values
   localparam logic [MODE_W-1:0] MODE_CUR = 4'h0;
   localparam logic [MODE_W-1:0] MODE_DO = 4'h1;
   localparam logic [MODE_W-1:0] MODE_SIG = 4'h2;
   localparam logic [MODE_W-1:0] MODE_CUR_AND_DO = 4'h3;
   localparam logic [MODE_W-1:0] MODE_CUR_OR_DO = 4'h4;
   localparam logic [MODE_W-1:0] MODE_CUR_AND_SIG = 4'h5;
   localparam logic [MODE_W-1:0] MODE_CUR_OR_SIG_DO = 4'h6;
   localparam logic [MODE_W-1:0] MODE_SIG_OR_DO = 4'h8;
   localparam logic [MODE_W-1:0] MODE_ANY = 4'h9;
   localparam logic [MODE_W-1:0] MODE_ALL = 4'ha;

   // event sources, also the status register bit positions
   localparam int EV_N = 8;
   localparam int EV_START = 0;
   localparam int EV_RETRIP = 1;
   localparam int EV_BFAIL = 2;
   localparam int EV_BLOCK = 3;
   localparam int EV_DO = 4;
   localparam int EV_SIG = 5;
   localparam int EV_PHASE = 6;
   localparam int EV_RES = 7;
   localparam int EV_OPS = 4;

   typedef struct packed {
      logic [TS_W-1:0] stamp;
      logic [3:0] code;
      logic [GROUP_W-1:0] group;
      logic [CUR_W-1:0] phase;
      logic [CUR_W-1:0] res;
      logic [DLY_W-1:0] to_retrip;
      logic [DLY_W-1:0] to_bfail;
   } bftl_entry_t;
endpackage
`default_nettype wire

// File: logic/bftl_log_if.sv
// link between the timer core and its operation log
`default_nettype none
interface bftl_log_if;
   import bftl_pkg::*;
   logic wr;
   bftl_entry_t entry;
   logic [LOG_IDX_W-1:0] rd_idx;
   logic [WORD_SEL_W-1:0] rd_word;
   logic [31:0] rd_data;
   logic [LOG_IDX_W-1:0] count;
   modport ctl (output wr, entry, rd_idx, rd_word, input rd_data, count);
   modport store (input wr, entry, rd_idx, rd_word, output rd_data, count);
endinterface
`default_nettype wire

// File: logic/bftl_log.sv
// circular log of the most recent operation records
`default_nettype none
module bftl_log
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   bftl_log_if.store log
);
   import bftl_pkg::*;

   typedef struct packed {
      bftl_entry_t [LOG_DEPTH-1:0] mem;
      logic [LOG_IDX_W-1:0] wptr;
      logic [LOG_IDX_W-1:0] count;
      logic [31:0] rd_data;
   } bftl_log_state_t;

   bftl_log_state_t st_q;
   bftl_log_state_t st_d;
   logic [LOG_IDX_W:0] phys;
   bftl_entry_t rd_e;

   always_comb
   begin
      st_d = st_q;
      if (log.wr)
      begin
         st_d.mem[st_q.wptr] = log.entry; // see [RL15]
         st_d.wptr = (st_q.wptr == LOG_IDX_W'(LOG_DEPTH - 1)) ?
            '0 : st_q.wptr + 1'b1;
         if (st_q.count != LOG_IDX_W'(LOG_DEPTH))
            st_d.count = st_q.count + 1'b1;
      end
      // index 0 is the newest record
      phys = {1'b0, st_q.wptr} + (LOG_IDX_W+1)'(LOG_DEPTH - 1)
         - {1'b0, log.rd_idx};
      if (phys >= (LOG_IDX_W+1)'(LOG_DEPTH))
         phys = phys - (LOG_IDX_W+1)'(LOG_DEPTH);
      rd_e = st_q.mem[phys[LOG_IDX_W-1:0]];
      st_d.rd_data = '0;
      if (log.rd_idx < st_q.count)
      begin
         case (log.rd_word) // see [RL16]
            3'h0: st_d.rd_data = rd_e.stamp;
            3'h1: st_d.rd_data = 32'({rd_e.group, rd_e.code});
            3'h2: st_d.rd_data = 32'(rd_e.phase);
            3'h3: st_d.rd_data = 32'(rd_e.res);
            3'h4: st_d.rd_data = 32'(rd_e.to_retrip);
            3'h5: st_d.rd_data = 32'(rd_e.to_bfail);
            default: st_d.rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign log.rd_data = st_q.rd_data;
   assign log.count = st_q.count;

   a_log_depth_cap: assert property (@(posedge clk_in) // see [RL15]
      disable iff (!rst_b_in)
      st_q.count <= LOG_IDX_W'(LOG_DEPTH))
      else $error("log count above depth");
endmodule
`default_nettype wire

// File: logic/bftl_top.sv
// breaker failure supervision timers, events and register slave
// What this block does
// [RL1] current-only: phase or residual pick-up starts both timers, trip ignored
// [RL2] current-only: retrip then breaker-fail when current stays up for delays
// [RL3] current-only: both timers clear once all currents drop below threshold
// [RL4] current-and-contact: timers held after pick-up until trip contact active
// [RL5] current-and-contact: with trip active, timers run to retrip and fail
// [RL6] current-and-contact: clear when current drops or trip contact releases
// [RL7] current-or-contact: pick-up active whenever current or trip is active
// [RL8] current-or-contact: outputs fire when either stays active through delay
// [RL9] current-or-contact: clear only when current low and trip released
// [RL10] without retrip the same criteria drive the breaker-fail timer alone
// [RL11] signals-only: digital input starts the timer, fail after the delay
// [RL12] events on changes of retrip, fail, blocked and pick-up comparators
// [RL13] user picks rising, falling or both edges per event source
// [RL14] every event carries a timestamp and current process values
// [RL15] circular log keeps the latest twelve operation records
// [RL16] record: time, event, max phase, residual, remaining times, group
// [RL17] selector chooses current, contact, signal or and/or mixes; current default
// [RL18] blocking at pick-up gives blocked indication and resets timing
// [RL19] delays in 5 ms steps up to 1800 s, defaults 100 ms and 200 ms
// [RL20] outputs held until timer clears, then both drop in one cycle
// [RL21] with retrip disabled the retrip output and its events stay off
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`default_nettype none
module bftl_top
#(
   parameter int TICK_CYCLES = bftl_pkg::TICK_CYCLES_DEF
)
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [bftl_pkg::ADR_W-1:0] WB_ADR_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic [3:0] WB_SEL_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic [bftl_pkg::CUR_W-1:0] PHASE_L1_IN,
   input wire logic [bftl_pkg::CUR_W-1:0] PHASE_L2_IN,
   input wire logic [bftl_pkg::CUR_W-1:0] PHASE_L3_IN,
   input wire logic [bftl_pkg::CUR_W-1:0] RESIDUAL_IN,
   input wire logic TRIP_MONITOR_IN,
   input wire logic SIGNAL_IN,
   input wire logic BLOCK_IN,
   input wire logic [bftl_pkg::TS_W-1:0] TIMESTAMP_IN,
   output logic START_OUT,
   output logic RETRIP_OUT,
   output logic BREAKER_FAIL_OUT,
   output logic BLOCKED_OUT,
   output logic EVENT_VALID_OUT,
   output logic [3:0] EVENT_CODE_OUT,
   output logic [bftl_pkg::TS_W-1:0] EVENT_STAMP_OUT,
   output logic [bftl_pkg::CUR_W-1:0] EVENT_PHASE_OUT,
   output logic [bftl_pkg::CUR_W-1:0] EVENT_RES_OUT
);
   import bftl_pkg::*;

   localparam int EV_LAT = 16;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [DLY_W-1:0] rt_dly;
      logic [DLY_W-1:0] bf_dly;
      logic [CUR_W-1:0] ph_thr;
      logic [CUR_W-1:0] res_thr;
      logic [15:0] mask;
      logic [7:0] log_sel;
      logic [TICK_W-1:0] div;
      logic [DLY_W-1:0] cnt;
      logic [EV_N-1:0] status;
      logic [EV_N-1:0] pend_on;
      logic [EV_N-1:0] pend_off;
      logic ev_valid;
      logic [3:0] ev_code;
      logic [TS_W-1:0] ev_stamp;
      logic [CUR_W-1:0] ev_phase;
      logic [CUR_W-1:0] ev_res;
      logic ack;
      logic [31:0] dat;
      logic log_wr;
      bftl_entry_t log_entry;
   } bftl_state_t;

   bftl_state_t st_q;
   bftl_state_t st_d;
   bftl_log_if log_link ();

   logic [MODE_W-1:0] mode;
   logic retrip_en;
   logic [CUR_W-1:0] phase_max;
   logic cur_ph;
   logic cur_res;
   logic cur_any;
   logic pick;
   logic run;
   logic go;
   logic tick;
   logic [EV_N-1:0] now;
   logic [EV_N-1:0] rise;
   logic [EV_N-1:0] fall;
   logic [EV_N-1:0] take_on;
   logic [EV_N-1:0] take_off;
   logic req;
   logic [ADR_W-1:0] adr;
   logic [31:0] rdata;

   function automatic logic [CUR_W-1:0] larger(input logic [CUR_W-1:0] a,
      input logic [CUR_W-1:0] b);
      return (a > b) ? a : b;
   endfunction

   function automatic logic [2:0] first_set(input logic [EV_N-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = EV_N - 1; i >= 0; i--)
         if (v[i])
            r = 3'(i);
      return r;
   endfunction

   function automatic logic [DLY_W-1:0] remaining(
      input logic [DLY_W-1:0] dly, input logic [DLY_W-1:0] cnt);
      return (cnt >= dly) ? '0 : dly - cnt;
   endfunction

   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[8*i +: 8] = new_v[8*i +: 8];
      return r;
   endfunction

   always_comb
   begin
      st_d = st_q;
      mode = st_q.ctrl[CTRL_MODE_LSB +: MODE_W];
      retrip_en = st_q.ctrl[CTRL_RETRIP_BIT];
      phase_max = larger(larger(PHASE_L1_IN, PHASE_L2_IN), PHASE_L3_IN);
      cur_ph = phase_max > st_q.ph_thr;
      cur_res = RESIDUAL_IN > st_q.res_thr;
      cur_any = cur_ph | cur_res;
      // pick is the start condition, run lets the timers count
      pick = cur_any;
      run = cur_any;
      case (mode) // see [RL17]
         MODE_CUR:
         begin
            pick = cur_any; // see [RL1]
            run = cur_any; // see [RL3]
         end
         MODE_DO:
         begin
            pick = TRIP_MONITOR_IN;
            run = TRIP_MONITOR_IN;
         end
         MODE_SIG:
         begin
            pick = SIGNAL_IN; // see [RL11]
            run = SIGNAL_IN;
         end
         MODE_CUR_AND_DO:
         begin
            pick = cur_any;
            run = cur_any & TRIP_MONITOR_IN; // see [RL4] [RL5] [RL6]
         end
         MODE_CUR_OR_DO:
         begin
            pick = cur_any | TRIP_MONITOR_IN; // see [RL7]
            run = pick; // see [RL9]
         end
         MODE_CUR_AND_SIG:
         begin
            pick = cur_any;
            run = cur_any & SIGNAL_IN;
         end
         MODE_CUR_OR_SIG_DO:
         begin
            pick = cur_any | (SIGNAL_IN & TRIP_MONITOR_IN);
            run = pick;
         end
         MODE_SIG_OR_DO:
         begin
            pick = SIGNAL_IN | TRIP_MONITOR_IN;
            run = pick;
         end
         MODE_ANY:
         begin
            pick = cur_any | TRIP_MONITOR_IN | SIGNAL_IN;
            run = pick;
         end
         MODE_ALL:
         begin
            pick = cur_any;
            run = cur_any & TRIP_MONITOR_IN & SIGNAL_IN;
         end
         default:
         begin
            pick = cur_any;
            run = cur_any;
         end
      endcase
      go = run & ~BLOCK_IN; // see [RL18]

      // step divider
      tick = st_q.div == TICK_W'(TICK_CYCLES - 1);
      st_d.div = tick ? '0 : st_q.div + 1'b1;

      // one count serves both timers
      if (!go)
         st_d.cnt = '0; // see [RL3] [RL6] [RL9] [RL20]
      else if (tick && st_q.cnt != '1)
         st_d.cnt = st_q.cnt + 1'b1; // see [RL19]

      now = '0;
      now[EV_START] = pick & ~BLOCK_IN;
      now[EV_RETRIP] = go & retrip_en & (st_d.cnt >= st_q.rt_dly); // see [RL2] [RL8] [RL21]
      now[EV_BFAIL] = go & (st_d.cnt >= st_q.bf_dly); // see [RL2] [RL8] [RL10]
      now[EV_BLOCK] = pick & BLOCK_IN; // see [RL18]
      now[EV_DO] = TRIP_MONITOR_IN;
      now[EV_SIG] = SIGNAL_IN;
      now[EV_PHASE] = cur_ph;
      now[EV_RES] = cur_res;
      st_d.status = now;
      rise = now & ~st_q.status; // see [RL12]
      fall = ~now & st_q.status;

      // emit one pending event per cycle, a new edge wins over the take
      take_on = '0;
      take_off = '0;
      st_d.ev_valid = 1'b0;
      if (|st_q.pend_on)
      begin
         take_on[first_set(st_q.pend_on)] = 1'b1;
         st_d.ev_valid = 1'b1;
         st_d.ev_code = {1'b1, first_set(st_q.pend_on)};
      end
      else if (|st_q.pend_off)
      begin
         take_off[first_set(st_q.pend_off)] = 1'b1;
         st_d.ev_valid = 1'b1;
         st_d.ev_code = {1'b0, first_set(st_q.pend_off)};
      end
      if (st_d.ev_valid)
      begin
         st_d.ev_stamp = TIMESTAMP_IN; // see [RL14]
         st_d.ev_phase = phase_max;
         st_d.ev_res = RESIDUAL_IN;
      end
      st_d.pend_on = (st_q.pend_on & ~take_on) | (rise & st_q.mask[7:0]); // see [RL13]
      st_d.pend_off = (st_q.pend_off & ~take_off) | (fall & st_q.mask[15:8]);

      // operation record on rising start, retrip, fail or blocked
      st_d.log_wr = |rise[EV_OPS-1:0]; // see [RL15]
      if (st_d.log_wr)
      begin
         st_d.log_entry.stamp = TIMESTAMP_IN; // see [RL16]
         st_d.log_entry.code = {1'b1, first_set(rise & 8'h0f)};
         st_d.log_entry.group = st_q.ctrl[CTRL_GROUP_LSB +: GROUP_W];
         st_d.log_entry.phase = phase_max;
         st_d.log_entry.res = RESIDUAL_IN;
         st_d.log_entry.to_retrip = remaining(st_q.rt_dly, st_d.cnt);
         st_d.log_entry.to_bfail = remaining(st_q.bf_dly, st_d.cnt);
      end

      // classic wishbone slave, answers one cycle after the request
      req = WB_CYC_IN & WB_STB_IN & ~st_q.ack;
      adr = {WB_ADR_IN[ADR_W-1:2], 2'b00};
      st_d.ack = req;
      rdata = '0;
      if (adr == REG_CTRL)
         rdata = 32'(st_q.ctrl);
      else if (adr == REG_RETRIP_DLY)
         rdata = 32'(st_q.rt_dly);
      else if (adr == REG_BFAIL_DLY)
         rdata = 32'(st_q.bf_dly);
      else if (adr == REG_PHASE_THR)
         rdata = 32'(st_q.ph_thr);
      else if (adr == REG_RES_THR)
         rdata = 32'(st_q.res_thr);
      else if (adr == REG_EVT_MASK)
         rdata = 32'(st_q.mask);
      else if (adr == REG_STATUS)
         rdata = 32'(st_q.status);
      else if (adr == REG_LOG_SEL)
         rdata = 32'({log_link.count, st_q.log_sel});
      else if (adr == REG_LOG_DATA)
         rdata = log_link.rd_data;
      if (req && !WB_WE_IN)
         st_d.dat = rdata;
      if (req && WB_WE_IN)
      begin
         if (adr == REG_CTRL)
            st_d.ctrl = 8'(lane_merge(32'(st_q.ctrl), WB_DAT_IN, WB_SEL_IN));
         else if (adr == REG_RETRIP_DLY)
            st_d.rt_dly = DLY_W'(lane_merge(32'(st_q.rt_dly), WB_DAT_IN,
               WB_SEL_IN));
         else if (adr == REG_BFAIL_DLY)
            st_d.bf_dly = DLY_W'(lane_merge(32'(st_q.bf_dly), WB_DAT_IN,
               WB_SEL_IN));
         else if (adr == REG_PHASE_THR)
            st_d.ph_thr = CUR_W'(lane_merge(32'(st_q.ph_thr), WB_DAT_IN,
               WB_SEL_IN));
         else if (adr == REG_RES_THR)
            st_d.res_thr = CUR_W'(lane_merge(32'(st_q.res_thr), WB_DAT_IN,
               WB_SEL_IN));
         else if (adr == REG_EVT_MASK)
            st_d.mask = 16'(lane_merge(32'(st_q.mask), WB_DAT_IN,
               WB_SEL_IN));
         else if (adr == REG_LOG_SEL)
            st_d.log_sel = 8'(lane_merge(32'(st_q.log_sel), WB_DAT_IN,
               WB_SEL_IN));
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         st_q <= '0;
         st_q.ctrl <= CTRL_RST;
         st_q.rt_dly <= RETRIP_DLY_RST;
         st_q.bf_dly <= BFAIL_DLY_RST;
         st_q.ph_thr <= PHASE_THR_RST;
         st_q.res_thr <= RES_THR_RST;
         st_q.mask <= EVT_MASK_RST;
      end
      else
         st_q <= st_d;
   end

   assign log_link.wr = st_q.log_wr;
   assign log_link.entry = st_q.log_entry;
   assign log_link.rd_idx = st_q.log_sel[LOG_IDX_W-1:0];
   assign log_link.rd_word = st_q.log_sel[LOG_WORD_LSB +: WORD_SEL_W];

   bftl_log u_log (
      .clk_in(SYS_CLK_IN),
      .rst_b_in(RST_B_IN),
      .log(log_link)
   );

   assign WB_DAT_OUT = st_q.dat;
   assign WB_ACK_OUT = st_q.ack;
   assign START_OUT = st_q.status[EV_START];
   assign RETRIP_OUT = st_q.status[EV_RETRIP];
   assign BREAKER_FAIL_OUT = st_q.status[EV_BFAIL];
   assign BLOCKED_OUT = st_q.status[EV_BLOCK];
   assign EVENT_VALID_OUT = st_q.ev_valid;
   assign EVENT_CODE_OUT = st_q.ev_code;
   assign EVENT_STAMP_OUT = st_q.ev_stamp;
   assign EVENT_PHASE_OUT = st_q.ev_phase;
   assign EVENT_RES_OUT = st_q.ev_res;

   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   sequence s_cur_low;
      mode == MODE_CUR && !cur_any;
   endsequence
   sequence s_cleared;
      st_q.cnt == '0 && !RETRIP_OUT && !BREAKER_FAIL_OUT;
   endsequence
   sequence s_sig_go;
      mode == MODE_SIG && SIGNAL_IN && !BLOCK_IN;
   endsequence

   a_retrip_gated: assert property (!$past(retrip_en) |-> !RETRIP_OUT) // see [RL21]
      else $error("retrip asserted while disabled");
   a_current_clear: assert property (s_cur_low |=> s_cleared) // see [RL3]
      else $error("timers not cleared after current dropped");
   a_and_halt: assert property ( // see [RL4]
      mode == MODE_CUR_AND_DO && cur_any && !TRIP_MONITOR_IN
      |=> st_q.cnt == '0 && !BREAKER_FAIL_OUT)
      else $error("timer ran without trip contact");
   a_or_hold: assert property ( // see [RL7]
      mode == MODE_CUR_OR_DO && (cur_any || TRIP_MONITOR_IN) && !BLOCK_IN
      |=> START_OUT)
      else $error("pick-up not held in or criterion");
   a_or_clear: assert property ( // see [RL9]
      mode == MODE_CUR_OR_DO && !cur_any && !TRIP_MONITOR_IN
      |=> s_cleared)
      else $error("or criterion timers not cleared");
   a_fail_delay: assert property ( // see [RL2]
      $rose(BREAKER_FAIL_OUT) |-> st_q.cnt >= $past(st_q.bf_dly))
      else $error("breaker fail before its delay");
   a_block_reset: assert property (BLOCK_IN |=> s_cleared ##0 !START_OUT) // see [RL18]
      else $error("blocking did not reset timing");
   a_sig_start: assert property (s_sig_go |=> START_OUT) // see [RL11]
      else $error("signal input did not start timer");
   a_drop_together: assert property ( // see [RL20]
      $past(RETRIP_OUT && BREAKER_FAIL_OUT) && !BREAKER_FAIL_OUT
      |-> !RETRIP_OUT)
      else $error("retrip outlived breaker fail");
   a_log_on_fail: assert property ($rose(BREAKER_FAIL_OUT) |-> st_q.log_wr) // see [RL15]
      else $error("fail rise not logged");
   a_event_emitted: assert property ( // see [RL12]
      $rose(RETRIP_OUT) && st_q.mask[EV_RETRIP]
      |-> ##[1:EV_LAT] (EVENT_VALID_OUT && EVENT_CODE_OUT == 4'h9))
      else $error("retrip on event missing");
   a_bus_ack_pulse: assert property (req |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
      else $error("bus ack not a single pulse");
endmodule
`default_nettype wire

// File: verif/bftl_trip_model.sv
// primary trip contact model with relay operate delay
`default_nettype none
module bftl_trip_model
#(
   parameter int OP_CYCLES = 2
)
(
   input wire logic clk_in,
   input wire logic trip_cmd_in,
   output logic contact_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [OP_CYCLES-1:0] pipe_q = '0;
   // contact closes and opens only after the relay operate time
   always @(posedge clk_in)
      pipe_q <= {pipe_q[OP_CYCLES-2:0], trip_cmd_in};
   assign contact_out = pipe_q[OP_CYCLES-1];
endmodule
`default_nettype wire

// File: verif/bftl_top_tb.sv
// self-checking bench of the breaker failure timer
`default_nettype none
module bftl_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bftl_pkg::*;
   logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, sig = 0, blk = 0;
   logic cmd = 0, mon, ack, evv, st, rtr, bf, bl;
   logic [ADR_W-1:0] adr = '0;
   logic [31:0] dw = '0, ts = '0, dr, q;
   logic [3:0] evc;
   logic [CUR_W-1:0] ph = '0;
   logic [CUR_W-1:0] rs = '0, evp, evr, ph_seen = '0, res_seen = '0;
   logic [31:0] evs, lag = '0;
   int errors = 0, samples_checked = 0, rtr_ev = 0, e0;
   bftl_top #(.TICK_CYCLES(10)) u_bftl_top (.SYS_CLK_IN(clk),
      .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_DAT_IN(dw), .WB_SEL_IN(4'hf), .WB_DAT_OUT(dr),
      .WB_ACK_OUT(ack), .PHASE_L1_IN(ph), .PHASE_L2_IN(16'h0000),
      .PHASE_L3_IN(16'h0000), .RESIDUAL_IN(rs),
      .TRIP_MONITOR_IN(mon), .SIGNAL_IN(sig), .BLOCK_IN(blk),
      .TIMESTAMP_IN(ts), .START_OUT(st), .RETRIP_OUT(rtr),
      .BREAKER_FAIL_OUT(bf), .BLOCKED_OUT(bl), .EVENT_VALID_OUT(evv),
      .EVENT_CODE_OUT(evc), .EVENT_STAMP_OUT(evs), .EVENT_PHASE_OUT(evp),
      .EVENT_RES_OUT(evr));
   bftl_trip_model u_bftl_trip_model (.clk_in(clk), .trip_cmd_in(cmd),
      .contact_out(mon));
   initial forever #10 clk = ~clk;
   always @(posedge clk)
      ts <= ts + 32'h1;
   // counts retrip on events, keeps the values events carry
   always @(posedge clk)
   begin
      if (evv === 1'b1 && evc === 4'h9)
      begin
         rtr_ev++;
         lag = ts - evs;
         ph_seen = evp;
      end
      if (evv === 1'b1 && evc === 4'hf)
         res_seen = evr;
   end
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [ADR_W-1:0] a,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      q = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic inp(input logic [CUR_W-1:0] p, input logic m,
      input logic s, input logic b);
      @(posedge clk);
      ph <= p;
      cmd <= m;
      sig <= s;
      blk <= b;
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // expected {start, retrip, fail, blocked}
   task automatic outs(input logic [3:0] e);
      chk("outputs", {28'h0, e}, {28'h0, st, rtr, bf, bl});
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", 32'h10, q);
      bus(1'b0, REG_RETRIP_DLY, 32'h0);
      chk("retrip delay", 32'd20, q);
      bus(1'b0, REG_BFAIL_DLY, 32'h0);
      chk("fail delay", 32'd40, q);
      bus(1'b0, 8'hfc, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b1, REG_RETRIP_DLY, 32'h2);
      bus(1'b1, REG_BFAIL_DLY, 32'h8);
      e0 = rtr_ev;
      inp(16'h0064, 1'b0, 1'b0, 1'b0);
      wt(3);
      outs(4'b1000);
      wt(40);
      outs(4'b1100);
      wt(60);
      outs(4'b1110);
      inp(16'h0000, 1'b0, 1'b0, 1'b0);
      wt(2);
      outs(4'b0000);
      chk("retrip events", e0 + 1, rtr_ev);
      chk("event stamp lag", 32'h1, lag);
      chk("event phase", 32'h64, {16'h0, ph_seen});
      bus(1'b0, REG_LOG_SEL, 32'h0);
      chk("log count", 32'h3, {28'h0, q[11:8]});
      bus(1'b1, REG_LOG_SEL, 32'h20);
      bus(1'b0, REG_LOG_DATA, 32'h0);
      chk("log max phase", 32'h64, q);
      bus(1'b1, REG_CTRL, 32'h13);
      inp(16'h0064, 1'b0, 1'b0, 1'b0);
      wt(60);
      outs(4'b1000);
      inp(16'h0064, 1'b1, 1'b0, 1'b0);
      wt(40);
      outs(4'b1100);
      inp(16'h0064, 1'b0, 1'b0, 1'b0);
      wt(4);
      outs(4'b1000);
      bus(1'b1, REG_CTRL, 32'h14);
      inp(16'h0000, 1'b1, 1'b0, 1'b0);
      wt(40);
      outs(4'b1100);
      inp(16'h0064, 1'b1, 1'b0, 1'b0);
      inp(16'h0064, 1'b0, 1'b0, 1'b0);
      wt(60);
      outs(4'b1110);
      inp(16'h0000, 1'b0, 1'b0, 1'b0);
      wt(4);
      outs(4'b0000);
      bus(1'b1, REG_CTRL, 32'h12);
      inp(16'h0000, 1'b0, 1'b1, 1'b0);
      wt(3);
      chk("fail early", 32'h0, {31'h0, bf});
      wt(100);
      chk("fail late", 32'h1, {31'h0, bf});
      inp(16'h0000, 1'b0, 1'b0, 1'b0);
      bus(1'b1, REG_CTRL, 32'h00);
      e0 = rtr_ev;
      inp(16'h0064, 1'b0, 1'b0, 1'b0);
      wt(100);
      outs(4'b1010);
      chk("no retrip events", e0, rtr_ev);
      inp(16'h0000, 1'b0, 1'b0, 1'b0);
      bus(1'b1, REG_EVT_MASK, 32'hfffd);
      bus(1'b1, REG_CTRL, 32'h10);
      e0 = rtr_ev;
      inp(16'h0064, 1'b0, 1'b0, 1'b0);
      wt(40);
      outs(4'b1100);
      chk("masked retrip events", e0, rtr_ev);
      inp(16'h0064, 1'b0, 1'b0, 1'b1);
      wt(3);
      outs(4'b0001);
      inp(16'h0000, 1'b0, 1'b0, 1'b0);
      wt(3);
      @(posedge clk);
      rs <= 16'h04b1;
      wt(3);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("status residual", 32'h81, q);
      chk("event res", 32'h4b1, {16'h0, res_seen});
      @(posedge clk);
      rs <= 16'h0000;
      bus(1'b1, REG_CTRL, 32'h1a);
      inp(16'h0064, 1'b1, 1'b0, 1'b0);
      wt(40);
      outs(4'b1000);
      inp(16'h0064, 1'b1, 1'b1, 1'b0);
      wt(40);
      outs(4'b1100);
      inp(16'h0000, 1'b0, 1'b0, 1'b0);
      wt(3);
      print_verdict();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
